// [hw/speed_hysteresis.sv]
// two-threshold hysteresis flag for signed speed comparisons
`timescale 1ns/1ps
`default_nettype none
module speed_hysteresis #(
  parameter int W = 18
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic signed [W-1:0] value,
  input wire logic signed [W-1:0] set_thr,
  input wire logic signed [W-1:0] clr_thr,
  output logic flag_q
);
  logic flag_d;

  // set strictly above set_thr, clear strictly below clr_thr, hold between
  assign flag_d = (value > set_thr) ? 1'b1 : ((value < clr_thr) ? 1'b0 : flag_q);

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end
endmodule // speed_hysteresis
`default_nettype wire

// [hw/status_output_selector.sv]
// multi-function status output selector for the drive's digital output terminals
//
// Summary of operation
// R1 - code 13: close while speed within width of reference, either direction
// R2 - code 14: close while speed and reference both within level plus/minus width
// R3 - code 15: open above level plus width, stay open until below level
// R4 - code 16: close above level, stay closed until below level minus width
// R5 - signed level sets direction; opposite travel never satisfies the compare (here it can for codes 14 and 16 when width exceeds the level)
// R6 - code 1A: close while driving down, open when up or stopped
// R7 - code 1B: open during baseblock, closed otherwise
// R8 - code 1C: open for first motor, closed for second motor
// R9 - code 1D: close while regenerating
// R10 - code 1E: close after reset attempt clears fault; open and fault when exhausted
// R11 - code 1F: close when overload estimate exceeds 90% of overload fault level
// R12 - code 20: close when heatsink temperature reaches alarm level
// R13 - code 30: close at torque limit, only in vector control modes
// R14 - code 33: close while rotor inside position lock band during lock
// R15 - code 37: close while outputting frequency, open on stop or braking
// R16 - code 50: closed requests brake release, open requests brake application
// R17 - code 51: closed requests contactor close; controller opens on release
// R18 - code 52: close once door zone speed reached; controller opens door
// R19 - code 53: closed above zero-speed level, open at zero speed
// R20 - code 54 gives light-load direction; code 55 closes when search done
// R21 - code 58: close if either safe-disable input open
// R22 - codes 100 to 161 select the low two digits inverted
// R23 - outputs registered as status xor invert, forced open in reset
`timescale 1ns/1ps
`default_nettype none
module status_output_selector #(
  parameter int NUM_TERM = 3,
  parameter int SPD_W = 16,
  parameter int OVL_W = 16,
  parameter int TEMP_W = 12,
  parameter int POS_W = 16,
  parameter int CNT_W = 4
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [NUM_TERM*status_out_pkg::CODE_W-1:0] func_sel,
  input wire logic signed [SPD_W-1:0] motor_speed,
  input wire logic signed [SPD_W-1:0] speed_ref,
  input wire logic signed [SPD_W-1:0] signed_speed_detect_level,
  input wire logic [SPD_W-2:0] speed_detect_width,
  input wire logic [SPD_W-2:0] door_zone_speed_level,
  input wire logic [SPD_W-2:0] zero_speed_level,
  input wire logic run_active,
  input wire logic drive_down,
  input wire logic baseblock,
  input wire logic motor2_active,
  input wire logic regen_active,
  input wire logic fault_active,
  input wire logic reset_attempt,
  input wire logic fault_reset_cmd,
  input wire logic [CNT_W-1:0] auto_reset_attempt_limit,
  input wire logic [OVL_W-1:0] overload_estimate,
  input wire logic [OVL_W-1:0] motor_overload_fault,
  input wire logic [TEMP_W-1:0] heatsink_temp,
  input wire logic [TEMP_W-1:0] heatsink_alarm_level,
  input wire logic torque_limit_hold,
  input wire logic open_loop_vector_mode,
  input wire logic closed_loop_vector_mode,
  input wire logic closed_loop_pm_mode,
  input wire logic position_lock_active,
  input wire logic signed [POS_W-1:0] rotor_position_error,
  input wire logic [POS_W-2:0] position_lock_band,
  input wire logic freq_output_active,
  input wire logic dc_injection_braking,
  input wire logic short_circuit_braking,
  input wire logic brake_release_req,
  input wire logic contactor_close_req,
  input wire logic light_load_dir_up,
  input wire logic light_load_search_busy,
  input wire logic safe_disable_input_a,
  input wire logic safe_disable_input_b,
  output logic [NUM_TERM-1:0] term_closed_q,
  output logic auto_reset_fault_q
);
  localparam int EW = SPD_W + 2;
  localparam int CW = status_out_pkg::CODE_W;
  localparam int SRC_N = int'(status_out_pkg::SRC_COUNT);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic signed [EW-1:0] sx(input logic signed [SPD_W-1:0] x);
    return EW'(x);
  endfunction

  function automatic logic signed [EW-1:0] mag(input logic signed [SPD_W-1:0] x);
    logic signed [EW-1:0] e;
    e = EW'(x);
    return (e < 0) ? -e : e;
  endfunction

  // ----------------------------------------------------------------
  // safe-disable pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] sd_meta_q;
  logic [1:0] sd_sync_q;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sd_meta_q <= '0;
      sd_sync_q <= '0;
    end else begin
      sd_meta_q <= {safe_disable_input_b, safe_disable_input_a};
      sd_sync_q <= sd_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // speed arithmetic
  // ----------------------------------------------------------------
  logic signed [EW-1:0] spd_e;
  logic signed [EW-1:0] ref_e;
  logic signed [EW-1:0] lvl_e;
  logic signed [EW-1:0] wid_e;
  logic signed [EW-1:0] dev_mag;
  logic lvl_neg;
  logic signed [EW-1:0] dir_spd;
  logic signed [EW-1:0] dir_lvl;
  logic signed [EW-1:0] det3_set;
  logic signed [EW-1:0] det4_clr;
  logic spd_in_band;
  logic ref_in_band;

  assign spd_e = sx(motor_speed);
  assign ref_e = sx(speed_ref);
  assign lvl_e = sx(signed_speed_detect_level);
  assign wid_e = EW'(speed_detect_width);
  assign dev_mag = (spd_e > ref_e) ? (spd_e - ref_e) : (ref_e - spd_e);
  // R5 direction from level sign
  assign lvl_neg = signed_speed_detect_level < 0;
  assign dir_spd = lvl_neg ? -spd_e : spd_e;
  assign dir_lvl = lvl_neg ? -lvl_e : lvl_e;
  assign det3_set = dir_lvl + wid_e;
  assign det4_clr = dir_lvl - wid_e;
  // signed band keeps the user agree direction-specific only while width does not exceed the level magnitude
  assign spd_in_band = (spd_e >= lvl_e - wid_e) && (spd_e <= lvl_e + wid_e);
  assign ref_in_band = (ref_e >= lvl_e - wid_e) && (ref_e <= lvl_e + wid_e);

  // ----------------------------------------------------------------
  // hysteresis detectors shared by all terminals
  // ----------------------------------------------------------------
  logic det3_over_q;
  logic det4_over_q;

  // R3 open above level plus width
  speed_hysteresis #(.W(EW)) u_det3 (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .value(dir_spd),
    .set_thr(det3_set),
    .clr_thr(dir_lvl),
    .flag_q(det3_over_q)
  );

  // R4 close above level
  speed_hysteresis #(.W(EW)) u_det4 (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .value(dir_spd),
    .set_thr(dir_lvl),
    .clr_thr(det4_clr),
    .flag_q(det4_over_q)
  );

  // ----------------------------------------------------------------
  // automatic reset tracking
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] attempt_cnt_q;
  logic attempt_pend_q;
  logic reset_en_q;
  logic limit_hit;

  assign limit_hit = reset_attempt && (attempt_cnt_q >= auto_reset_attempt_limit);

  // R10 reset-enabled and exhaustion
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      attempt_cnt_q <= '0;
      attempt_pend_q <= 1'b0;
      reset_en_q <= 1'b0;
      auto_reset_fault_q <= 1'b0;
    end else if (limit_hit) begin
      attempt_pend_q <= 1'b0;
      reset_en_q <= 1'b0;
      auto_reset_fault_q <= 1'b1;
    end else if (fault_reset_cmd) begin
      attempt_cnt_q <= '0;
      attempt_pend_q <= 1'b0;
      reset_en_q <= 1'b0;
      auto_reset_fault_q <= 1'b0;
    end else if (reset_attempt && !auto_reset_fault_q) begin
      attempt_cnt_q <= attempt_cnt_q + 1'b1;
      attempt_pend_q <= 1'b1;
    end else if (attempt_pend_q && !fault_active) begin
      attempt_pend_q <= 1'b0;
      reset_en_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // status source vector
  // ----------------------------------------------------------------
  logic [SRC_N-1:0] src;
  logic [OVL_W+3:0] ovl_scaled;
  logic [OVL_W+3:0] ovl_thr;
  logic signed [POS_W:0] pos_e;
  logic [POS_W:0] pos_mag;
  logic vector_mode;

  assign ovl_scaled = (OVL_W+4)'(overload_estimate) * (OVL_W+4)'(status_out_pkg::OVL_ALARM_DEN);
  assign ovl_thr = (OVL_W+4)'(motor_overload_fault) * (OVL_W+4)'(status_out_pkg::OVL_ALARM_NUM);
  assign pos_e = (POS_W+1)'(rotor_position_error);
  assign pos_mag = (pos_e < 0) ? (POS_W+1)'(-pos_e) : (POS_W+1)'(pos_e);
  assign vector_mode = open_loop_vector_mode | closed_loop_vector_mode | closed_loop_pm_mode;

  assign src[status_out_pkg::SRC_NONE] = 1'b0;
  // R1 agree, both directions
  assign src[status_out_pkg::SRC_AGREE2] = dev_mag <= wid_e;
  // R2 both within band
  assign src[status_out_pkg::SRC_USER_AGREE2] = spd_in_band && ref_in_band;
  assign src[status_out_pkg::SRC_DET3] = !det3_over_q;
  assign src[status_out_pkg::SRC_DET4] = det4_over_q;
  // R6 down direction
  assign src[status_out_pkg::SRC_DOWN] = run_active && drive_down;
  // R7 baseblock n.c.
  assign src[status_out_pkg::SRC_BB_NC] = !baseblock;
  // R8 motor select
  assign src[status_out_pkg::SRC_MOTOR2] = motor2_active;
  // R9 regeneration
  assign src[status_out_pkg::SRC_REGEN] = regen_active;
  assign src[status_out_pkg::SRC_RESET_EN] = reset_en_q;
  // R11 overload pre-alarm
  assign src[status_out_pkg::SRC_OVL] = ovl_scaled > ovl_thr;
  // R12 heatsink alarm
  assign src[status_out_pkg::SRC_OH] = heatsink_temp >= heatsink_alarm_level;
  // R13 torque limit in vector modes
  assign src[status_out_pkg::SRC_TRQ_LIM] = torque_limit_hold && vector_mode;
  // R14 position lock band
  assign src[status_out_pkg::SRC_POS_LOCK] =
    position_lock_active && (pos_mag <= (POS_W+1)'(position_lock_band));
  // R15 frequency output
  assign src[status_out_pkg::SRC_FREQ_OUT] = freq_output_active && run_active && !baseblock &&
    !dc_injection_braking && !short_circuit_braking;
  // R16 brake release request
  assign src[status_out_pkg::SRC_BRAKE] = brake_release_req;
  // R17 contactor request
  assign src[status_out_pkg::SRC_CONTACTOR] = contactor_close_req;
  // R18 door zone speed
  assign src[status_out_pkg::SRC_DOOR_ZONE] =
    run_active && (mag(motor_speed) <= EW'(door_zone_speed_level));
  // R19 not zero speed
  assign src[status_out_pkg::SRC_NOT_ZERO] = mag(motor_speed) > EW'(zero_speed_level);
  // R20 light-load direction and done
  assign src[status_out_pkg::SRC_LL_DIR] = light_load_dir_up;
  assign src[status_out_pkg::SRC_LL_DONE] = !light_load_search_busy;
  // R21 either safe-disable open
  assign src[status_out_pkg::SRC_SAFE_DIS] = !(sd_sync_q[0] && sd_sync_q[1]);

  // ----------------------------------------------------------------
  // per-terminal selection
  // ----------------------------------------------------------------
  logic [NUM_TERM-1:0] term_d;

  for (genvar t = 0; t < NUM_TERM; t++) begin : g_term
    logic [CW-1:0] code;
    logic [3:0] prefix;
    logic [status_out_pkg::FN_W-1:0] fn;
    logic code_ok;
    logic inv;
    status_out_pkg::src_type sel;

    assign code = func_sel[t*CW +: CW];
    assign prefix = code[status_out_pkg::PREFIX_LSB +: 4];
    assign fn = code[status_out_pkg::FN_LSB +: status_out_pkg::FN_W];
    // R22 leading one inverts
    assign inv = prefix == status_out_pkg::PREFIX_INVERT;
    assign code_ok = (prefix == status_out_pkg::PREFIX_NORMAL) ||
      (inv && fn <= status_out_pkg::FN_MAX);
    assign sel = code_ok ? status_out_pkg::fn_src(fn) : status_out_pkg::SRC_NONE;
    // R23 status xor invert; invalid prefixes and inverted codes above 161 stay open
    assign term_d[t] = code_ok && (src[sel] ^ inv);
  end

  // R23 registered, open in reset
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      term_closed_q <= '0;
    end else begin
      term_closed_q <= term_d;
    end
  end

  // ----------------------------------------------------------------
  // checks on terminal 0, plus reset of all terminals and reset exhaustion
  // ----------------------------------------------------------------
  logic [CW-1:0] code0;
  assign code0 = func_sel[CW-1:0];

  sequence s_det3_over;
    code0 == CW'(status_out_pkg::FN_SPD_DET3) && dir_spd > det3_set;
  endsequence

  sequence s_det3_hold;
    code0 == CW'(status_out_pkg::FN_SPD_DET3) && dir_spd >= dir_lvl;
  endsequence

  property p_agree;
    @(posedge mclk) disable iff (sys_rst)
      code0 == CW'(status_out_pkg::FN_SPD_AGREE2) |=> term_closed_q[0] == $past(dev_mag <= wid_e);
  endproperty
  a_agree: assert property (p_agree) else $error("speed agree output wrong"); // R1

  property p_user;
    @(posedge mclk) disable iff (sys_rst)
      code0 == CW'(status_out_pkg::FN_USER_AGREE2) && !spd_in_band |=> !term_closed_q[0];
  endproperty
  a_user: assert property (p_user) else $error("user agree closed out of band"); // R2

  property p_det3;
    @(posedge mclk) disable iff (sys_rst)
      s_det3_over ##1 s_det3_hold |=> !term_closed_q[0];
  endproperty
  a_det3: assert property (p_det3) else $error("detection 3 not held open"); // R3

  property p_det4;
    @(posedge mclk) disable iff (sys_rst)
      code0 == CW'(status_out_pkg::FN_SPD_DET4) && dir_spd > dir_lvl ##1
      code0 == CW'(status_out_pkg::FN_SPD_DET4) && dir_spd >= det4_clr |=> term_closed_q[0];
  endproperty
  a_det4: assert property (p_det4) else $error("detection 4 not held closed"); // R4

  property p_dir;
    @(posedge mclk) disable iff (sys_rst)
      code0 == CW'(status_out_pkg::FN_USER_AGREE2) && lvl_e > wid_e && spd_e < 0
      |=> !term_closed_q[0];
  endproperty
  a_dir: assert property (p_dir) else $error("opposite direction satisfied agree"); // R5

  property p_down;
    @(posedge mclk) disable iff (sys_rst)
      code0 == CW'(status_out_pkg::FN_DOWN) |=> term_closed_q[0] == $past(run_active && drive_down);
  endproperty
  a_down: assert property (p_down) else $error("down direction output wrong"); // R6

  property p_bb;
    @(posedge mclk) disable iff (sys_rst)
      code0 == CW'(status_out_pkg::FN_BB_NC) && baseblock |=> !term_closed_q[0];
  endproperty
  a_bb: assert property (p_bb) else $error("closed during baseblock"); // R7

  property p_safe;
    @(posedge mclk) disable iff (sys_rst)
      code0 == CW'(status_out_pkg::FN_SAFE_DIS) && !safe_disable_input_a [*3]
      |=> term_closed_q[0];
  endproperty
  a_safe: assert property (p_safe) else $error("safe disable open not reported"); // R21

  property p_inv;
    @(posedge mclk) disable iff (sys_rst)
      code0 == {status_out_pkg::PREFIX_INVERT, status_out_pkg::FN_REGEN}
      |=> term_closed_q[0] == !$past(regen_active);
  endproperty
  a_inv: assert property (p_inv) else $error("inverted output wrong"); // R22

  property p_rst;
    @(posedge mclk) sys_rst |=> term_closed_q == '0;
  endproperty
  a_rst: assert property (p_rst) else $error("terminal not open after reset"); // R23

  property p_exhaust;
    @(posedge mclk) disable iff (sys_rst)
      limit_hit |=> auto_reset_fault_q && !reset_en_q;
  endproperty
  a_exhaust: assert property (p_exhaust) else $error("exhausted reset not faulted"); // R10
endmodule // status_output_selector
`default_nettype wire

// [include/status_out_pkg.sv]
// constants, function codes and source selection for the status output stage
`default_nettype none
package status_out_pkg;
  // ----------------------------------------------------------------
  // setting code layout
  // ----------------------------------------------------------------
  localparam int CODE_W = 12;
  localparam int FN_W = 8;
  localparam int FN_LSB = 0;
  localparam int PREFIX_LSB = 8;
  localparam logic [3:0] PREFIX_NORMAL = 4'h0;
  localparam logic [3:0] PREFIX_INVERT = 4'h1;
  localparam logic [FN_W-1:0] FN_MAX = 8'h61;

  // ----------------------------------------------------------------
  // function codes
  // ----------------------------------------------------------------
  localparam logic [FN_W-1:0] FN_SPD_AGREE2 = 8'h13;
  localparam logic [FN_W-1:0] FN_USER_AGREE2 = 8'h14;
  localparam logic [FN_W-1:0] FN_SPD_DET3 = 8'h15;
  localparam logic [FN_W-1:0] FN_SPD_DET4 = 8'h16;
  localparam logic [FN_W-1:0] FN_DOWN = 8'h1A;
  localparam logic [FN_W-1:0] FN_BB_NC = 8'h1B;
  localparam logic [FN_W-1:0] FN_MOTOR2 = 8'h1C;
  localparam logic [FN_W-1:0] FN_REGEN = 8'h1D;
  localparam logic [FN_W-1:0] FN_RESET_EN = 8'h1E;
  localparam logic [FN_W-1:0] FN_OVL_ALARM = 8'h1F;
  localparam logic [FN_W-1:0] FN_OH_PRE = 8'h20;
  localparam logic [FN_W-1:0] FN_TRQ_LIM = 8'h30;
  localparam logic [FN_W-1:0] FN_POS_LOCK = 8'h33;
  localparam logic [FN_W-1:0] FN_FREQ_OUT = 8'h37;
  localparam logic [FN_W-1:0] FN_BRAKE = 8'h50;
  localparam logic [FN_W-1:0] FN_CONTACTOR = 8'h51;
  localparam logic [FN_W-1:0] FN_DOOR_ZONE = 8'h52;
  localparam logic [FN_W-1:0] FN_NOT_ZERO = 8'h53;
  localparam logic [FN_W-1:0] FN_LL_DIR = 8'h54;
  localparam logic [FN_W-1:0] FN_LL_DONE = 8'h55;
  localparam logic [FN_W-1:0] FN_SAFE_DIS = 8'h58;

  // ----------------------------------------------------------------
  // overload pre-alarm ratio, 90 percent as 9/10
  // ----------------------------------------------------------------
  localparam int OVL_RATIO_W = 4;
  localparam logic [OVL_RATIO_W-1:0] OVL_ALARM_NUM = 4'h9;
  localparam logic [OVL_RATIO_W-1:0] OVL_ALARM_DEN = 4'hA;

  // ----------------------------------------------------------------
  // status sources
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    SRC_NONE, SRC_AGREE2, SRC_USER_AGREE2, SRC_DET3, SRC_DET4, SRC_DOWN,
    SRC_BB_NC, SRC_MOTOR2, SRC_REGEN, SRC_RESET_EN, SRC_OVL, SRC_OH,
    SRC_TRQ_LIM, SRC_POS_LOCK, SRC_FREQ_OUT, SRC_BRAKE, SRC_CONTACTOR,
    SRC_DOOR_ZONE, SRC_NOT_ZERO, SRC_LL_DIR, SRC_LL_DONE, SRC_SAFE_DIS,
    SRC_COUNT
  } src_type;

  function automatic src_type fn_src(input logic [FN_W-1:0] f);
    src_type s;
    s = SRC_NONE;
    if (f == FN_SPD_AGREE2) s = SRC_AGREE2;
    else if (f == FN_USER_AGREE2) s = SRC_USER_AGREE2;
    else if (f == FN_SPD_DET3) s = SRC_DET3;
    else if (f == FN_SPD_DET4) s = SRC_DET4;
    else if (f == FN_DOWN) s = SRC_DOWN;
    else if (f == FN_BB_NC) s = SRC_BB_NC;
    else if (f == FN_MOTOR2) s = SRC_MOTOR2;
    else if (f == FN_REGEN) s = SRC_REGEN;
    else if (f == FN_RESET_EN) s = SRC_RESET_EN;
    else if (f == FN_OVL_ALARM) s = SRC_OVL;
    else if (f == FN_OH_PRE) s = SRC_OH;
    else if (f == FN_TRQ_LIM) s = SRC_TRQ_LIM;
    else if (f == FN_POS_LOCK) s = SRC_POS_LOCK;
    else if (f == FN_FREQ_OUT) s = SRC_FREQ_OUT;
    else if (f == FN_BRAKE) s = SRC_BRAKE;
    else if (f == FN_CONTACTOR) s = SRC_CONTACTOR;
    else if (f == FN_DOOR_ZONE) s = SRC_DOOR_ZONE;
    else if (f == FN_NOT_ZERO) s = SRC_NOT_ZERO;
    else if (f == FN_LL_DIR) s = SRC_LL_DIR;
    else if (f == FN_LL_DONE) s = SRC_LL_DONE;
    else if (f == FN_SAFE_DIS) s = SRC_SAFE_DIS;
    return s;
  endfunction
endpackage
`default_nettype wire

// [verification/elevator_ctrl_model.sv]
// far-side controller model that follows one status terminal
`timescale 1ns/1ps
`default_nettype none
module elevator_ctrl_model (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic term,
  output logic brake_released,
  output logic contactor_closed,
  output logic door_open
);
  always_ff @(posedge mclk) begin
    brake_released <= !sys_rst && term;
    contactor_closed <= !sys_rst && term;
    door_open <= !sys_rst && term;
  end
endmodule // elevator_ctrl_model
`default_nettype wire

// [verification/tb_multi_function_status_output_selector.sv]
// self-checking bench for the status output selector
`timescale 1ns/1ps
`default_nettype none
module tb_multi_function_status_output_selector;
  logic mclk;
  logic sys_rst = 1'h1;
  logic [35:0] func_sel = 36'h0_0000_001b;
  logic signed [15:0] ms = 16'h0000, sr = 16'h0000, lvl = 16'h0000, pe = 16'h0000;
  logic [14:0] w = 15'h0000, dz = 15'h0000, zs = 15'h0000, pb = 15'h0000;
  // lv: run down bb m2 regen trq olv clv closed_loop_pm_mode lock freq dc sc brake cont dir_up
  logic [15:0] lv = 16'h0000, oe = 16'h0000, of = 16'h0000;
  logic [11:0] ht = 12'h000, ha = 12'h000;
  logic [3:0] lim = 4'h2;
  logic fa = 1'h0, ra = 1'h0, fc = 1'h0, bz = 1'h0, sa = 1'h1, sb = 1'h1;
  logic fx = 1'h0, ren = 1'h0, hf = 1'h0;
  logic [2:0] term_closed_q;
  logic auto_reset_fault_q;
  // lfsr seed 13542
  logic [15:0] r = 16'h34e6;
  logic [3:0] exp_q[$];
  int failures = 0, compares = 0, cyc = 0;
  logic [7:0] fns[20] = '{8'h13, 8'h14, 8'h1a, 8'h1b, 8'h1c, 8'h1d, 8'h1e, 8'h1f, 8'h20,
    8'h30, 8'h33, 8'h37, 8'h50, 8'h51, 8'h52, 8'h53, 8'h54, 8'h55, 8'h58, 8'h2f};

  elevator_ctrl_model i_elevator_ctrl_model (.mclk, .sys_rst, .term(term_closed_q[0]),
    .brake_released(), .contactor_closed(), .door_open());

  status_output_selector i_status_output_selector (.mclk, .sys_rst, .func_sel,
    .motor_speed(ms), .speed_ref(sr), .signed_speed_detect_level(lvl), .speed_detect_width(w),
    .door_zone_speed_level(dz), .zero_speed_level(zs), .run_active(lv[0]), .drive_down(lv[1]),
    .baseblock(lv[2]), .motor2_active(lv[3]), .regen_active(lv[4]), .fault_active(fa),
    .reset_attempt(ra), .fault_reset_cmd(fc), .auto_reset_attempt_limit(lim),
    .overload_estimate(oe), .motor_overload_fault(of), .heatsink_temp(ht),
    .heatsink_alarm_level(ha), .torque_limit_hold(lv[5]), .open_loop_vector_mode(lv[6]),
    .closed_loop_vector_mode(lv[7]), .closed_loop_pm_mode(lv[8]),
    .position_lock_active(lv[9]), .rotor_position_error(pe), .position_lock_band(pb),
    .freq_output_active(lv[10]), .dc_injection_braking(lv[11]),
    .short_circuit_braking(lv[12]), .brake_release_req(lv[13]), .contactor_close_req(lv[14]),
    .light_load_dir_up(lv[15]), .light_load_search_busy(bz), .safe_disable_input_a(sa),
    .safe_disable_input_b(sb), .term_closed_q, .auto_reset_fault_q);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'h0;
    forever #20 mclk = ~mclk;
  end

  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // expected terminal state, worked out from the bench's own inputs
  function automatic logic stat(input logic [7:0] fn);
    int m = ms;
    int s = sr;
    int l = lvl;
    int p = pe;
    int v = w;
    // widen the unsigned bands first so a negative speed compares signed
    int b = pb;
    int dl = dz;
    int zl = zs;
    case (fn)
      8'h13: return (m - s <= v) && (s - m <= v);
      8'h14: return m >= l - v && m <= l + v && s >= l - v && s <= l + v;
      8'h15: return !hf;
      8'h16: return hf;
      8'h1a: return lv[0] & lv[1];
      8'h1b: return !lv[2];
      8'h1c: return lv[3];
      8'h1d: return lv[4];
      8'h1e: return ren;
      8'h1f: return oe * 4'ha > of * 4'h9;
      8'h20: return ht >= ha;
      8'h30: return lv[5] & |lv[8:6];
      8'h33: return lv[9] && p <= b && -p <= b;
      8'h37: return lv[10] & lv[0] & !lv[2] & !lv[11] & !lv[12];
      8'h50: return lv[13];
      8'h51: return lv[14];
      8'h52: return lv[0] && m <= dl && -m <= dl;
      8'h53: return m > zl || -m > zl;
      8'h54: return lv[15];
      8'h55: return !bz;
      8'h58: return !(sa & sb);
      default: return 1'h0;
    endcase
  endfunction

  task automatic check(input string nm, input logic [3:0] seen, input logic [3:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // terminal 1 carries the opposite polarity to terminal 0, terminal 2 an invalid prefix
  task automatic settle(input logic [7:0] fn, input logic inv);
    logic st;
    func_sel <= {4'h2, fn, 3'h0, !inv, fn, 3'h0, inv, fn};
    @(posedge mclk);
    st = stat(fn);
    // safe-disable path is the slowest at three edges
    repeat (2) @(posedge mclk);
    exp_q.push_back({fx, 1'h0, st ^ !inv, st ^ inv});
  endtask

  task automatic rnd_all();
    r = nxt(r);
    ms <= {{8{r[7]}}, r[7:0]};
    sr <= {{8{r[15]}}, r[15:8]};
    r = nxt(r);
    lvl <= {{8{r[7]}}, r[7:0]};
    w <= {9'h000, r[13:8]};
    r = nxt(r);
    lv <= r;
    r = nxt(r);
    {bz, sa, sb} <= r[2:0];
    dz <= {8'h00, r[9:3]};
    zs <= {11'h000, r[13:10]};
    r = nxt(r);
    oe <= {8'h00, r[7:0]};
    of <= {8'h00, r[15:8]};
    pe <= {{8{r[7]}}, r[7:0]};
    r = nxt(r);
    ht <= {4'h0, r[7:0]};
    ha <= {4'h0, r[15:8]};
    pb <= {9'h000, r[13:8]};
    r = nxt(r);
  endtask

  task automatic det_scen();
    int sp[12] = '{0, 20, 21, 30, 31, 20, 19, 10, 9, -31, -21, -9};
    int d;
    w <= 15'h000a;
    for (int c = 0; c < 2; c++) begin
      for (int k = 0; k < 2; k++) begin
        foreach (sp[i]) begin
          lvl <= k ? 16'hffec : 16'h0014;
          d = k ? -sp[i] : sp[i];
          ms <= sp[i][15:0];
          if (d > (c ? 20 : 30)) hf = 1'h1;
          else if (d < (c ? 10 : 20)) hf = 1'h0;
          settle(c ? 8'h16 : 8'h15, k[0]);
        end
      end
    end
  endtask

  task automatic pulse();
    ra <= 1'h1;
    @(posedge mclk);
    ra <= 1'h0;
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // stimulus, monitor and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge mclk);
    exp_q.push_back(4'h0);
    sys_rst <= 1'h0;
    repeat (200) begin
      rnd_all();
      settle(fns[r % 16'h0014], r[15]);
    end
    det_scen();
    fa <= 1'h1;
    pulse();
    settle(8'h1e, 1'h0);
    fa <= 1'h0;
    ren = 1'h1;
    settle(8'h1e, 1'h0);
    pulse();
    settle(8'h1e, 1'h1);
    pulse();
    fx = 1'h1;
    ren = 1'h0;
    settle(8'h1e, 1'h0);
    fc <= 1'h1;
    @(posedge mclk);
    fc <= 1'h0;
    fx = 1'h0;
    settle(8'h1e, 1'h0);
    repeat (2) @(posedge mclk);
    test_done();
  end

  always @(negedge mclk) begin
    if (exp_q.size() > 0) begin
      check("terminals", {auto_reset_fault_q, term_closed_q}, exp_q.pop_front());
    end
  end

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      failures++;
      test_done();
    end
  end
endmodule // tb_multi_function_status_output_selector
`default_nettype wire
